/* File: rtl/bms_sequencer.sv */
`timescale 1ns/1ns
// Overview of operation
// - With sleep enabled, both bus lines low for the timeout puts device asleep.
// - Voltage selector cycles battery, aux zero, aux one, forever in that order.
// - Divider supply output turns off once auxiliary conversions complete.
// - Divider output disable keeps the divider supply off entirely.
// - Each current result is stored signed in a two-byte readable register.
// - Every completed current result is added into the accumulated charge count, except when a host write to that count lands in the same cycle.
// - Sleep stops all conversions and holds the accumulated charge count.
// - Bus-low sleep entry only when sleep is enabled; otherwise stay active.
// - Host reads configuration and measurement registers over the link; it can write only configuration and the accumulated charge count.
// - Aux results are ratiometric to divider supply; battery uses internal reference.
// - While active, current conversions run back to back without pause.
// - Either bus line sensed high wakes the device at once.
// - Each voltage conversion slot lasts 220 ms.
// - Current register refreshes every 878 ms with that period's average.
// - Divider supply turns on one precharge interval before aux zero begins.
module bms_sequencer
#(
   parameter int BUS_LOW_CYC = bms_pkg::BMS_BUS_LOW_TIMEOUT_CYC,
   parameter int SLOT_CYC = bms_pkg::BMS_SLOT_CYC,
   parameter int CUR_PERIOD_CYC = bms_pkg::BMS_CUR_PERIOD_CYC,
   parameter int PRECHARGE_CYC = bms_pkg::BMS_DIVIDER_PRECHARGE_CYC
)
(
   // Core clock, reset, enable
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   // Link clock domain host access
   input wire logic link_clk,
   input wire logic link_rst_n,
   input wire logic host_req_valid,
   input wire bms_pkg::bms_req_s host_req,
   output logic host_req_ready,
   output logic host_rd_valid,
   output logic [15:0] host_rd_data,
   // Two-wire bus line levels
   input wire logic scl_in,
   input wire logic sda_in,
   // Voltage converter
   output bms_pkg::bms_vconv_s vconv,
   input wire logic [15:0] vconv_avg,
   // Current converter
   output logic cur_run,
   output logic cur_dump,
   input wire logic [15:0] cur_avg,
   // Divider supply and mode
   output logic divider_supply_output,
   output logic sleeping
);
   import bms_pkg::*;

   bms_mode_e mode_q;
   bms_sel_e sel_q;
   logic sleep_enable_bit_q;
   logic divider_output_disable_q;
   logic [31:0] slot_cnt_q;
   logic [31:0] cur_cnt_q;
   logic [31:0] low_cnt_q;
   logic [15:0] current_q;
   logic [15:0] accumulated_charge_count_q;
   logic [15:0] voltage_q;
   logic [15:0] aux0_q;
   logic [15:0] aux1_q;
   logic [15:0] rsp_q;
   logic div_q;
   logic scl_s1_q;
   logic scl_s2_q;
   logic sda_s1_q;
   logic sda_s2_q;
   logic req_s1_q;
   logic req_s2_q;
   logic req_s3_q;
   logic ack_q;
   logic req_toggle;
   bms_req_s req_hold;
   logic active;
   logic slot_end;
   logic cur_end;
   logic bus_low;
   logic access;
   logic wr_cfg;
   logic wr_accum;
   logic precharge;
   logic div_d;
   logic [17:0] acc_sum;
   logic [15:0] acc_d;
   logic [15:0] rd_mux;

   // ============================================================
   // Link domain port
   // ============================================================
   bms_link_port u_link
   (
      .link_clk(link_clk),
      .link_rst_n(link_rst_n),
      .host_req_valid(host_req_valid),
      .host_req(host_req),
      .host_req_ready(host_req_ready),
      .host_rd_valid(host_rd_valid),
      .host_rd_data(host_rd_data),
      .req_toggle_q(req_toggle),
      .req_hold_q(req_hold),
      .ack_toggle(ack_q),
      .rsp_data(rsp_q)
   );

   // ============================================================
   // Synchronisers for bus levels and request toggle
   // ============================================================
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         scl_s1_q <= 1'b0;
         scl_s2_q <= 1'b0;
         sda_s1_q <= 1'b0;
         sda_s2_q <= 1'b0;
         req_s1_q <= 1'b0;
         req_s2_q <= 1'b0;
         req_s3_q <= 1'b0;
      end
      else if (clk_en)
      begin
         scl_s1_q <= scl_in;
         scl_s2_q <= scl_s1_q;
         sda_s1_q <= sda_in;
         sda_s2_q <= sda_s1_q;
         req_s1_q <= req_toggle;
         req_s2_q <= req_s1_q;
         req_s3_q <= req_s2_q;
      end
   end

   assign active = (mode_q == BMS_ACTIVE);
   assign bus_low = ~scl_s2_q & ~sda_s2_q;
   assign access = req_s2_q ^ req_s3_q;
   assign wr_cfg = access && req_hold.write && (req_hold.addr == BMS_REG_CFG);
   assign wr_accum = access && req_hold.write && (req_hold.addr == BMS_REG_ACCUM);

   // ============================================================
   // Power mode
   // ============================================================
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         low_cnt_q <= 32'h00000000;
      end
      else if (clk_en)
      begin
         if (active && sleep_enable_bit_q && bus_low)
         begin
            low_cnt_q <= low_cnt_q + 32'h00000001;
         end
         else
         begin
            low_cnt_q <= 32'h00000000;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         mode_q <= BMS_ACTIVE;
      end
      else if (clk_en)
      begin
         case (mode_q)
            BMS_ACTIVE:
            begin
               if (sleep_enable_bit_q && bus_low
                   && (low_cnt_q == 32'(BUS_LOW_CYC - 1)))
               begin
                  mode_q <= BMS_SLEEP;
               end
            end
            BMS_SLEEP:
            begin
               if (!bus_low)
               begin
                  mode_q <= BMS_ACTIVE;
               end
            end
            default:
            begin
               mode_q <= BMS_ACTIVE;
            end
         endcase
      end
   end

   assign sleeping = (mode_q == BMS_SLEEP);

   // ============================================================
   // Voltage sequence
   // ============================================================
   assign slot_end = active && (slot_cnt_q == 32'(SLOT_CYC - 1));

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         slot_cnt_q <= 32'h00000000;
         sel_q <= BMS_SEL_BATT;
      end
      else if (clk_en && active)
      begin
         if (slot_end)
         begin
            slot_cnt_q <= 32'h00000000;
            case (sel_q)
               BMS_SEL_BATT: sel_q <= BMS_SEL_AUX0;
               BMS_SEL_AUX0: sel_q <= BMS_SEL_AUX1;
               BMS_SEL_AUX1: sel_q <= BMS_SEL_BATT;
               default: sel_q <= BMS_SEL_BATT;
            endcase
         end
         else
         begin
            slot_cnt_q <= slot_cnt_q + 32'h00000001;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         voltage_q <= BMS_MEAS_RESET;
         aux0_q <= BMS_MEAS_RESET;
         aux1_q <= BMS_MEAS_RESET;
      end
      else if (clk_en && slot_end)
      begin
         case (sel_q)
            BMS_SEL_BATT: voltage_q <= vconv_avg;
            BMS_SEL_AUX0: aux0_q <= vconv_avg;
            BMS_SEL_AUX1: aux1_q <= vconv_avg;
            default: voltage_q <= voltage_q;
         endcase
      end
   end

   assign vconv.sel = sel_q;
   assign vconv.ratiometric = (sel_q != BMS_SEL_BATT);
   assign vconv.run = active;
   assign vconv.dump = slot_end;

   // ============================================================
   // Divider supply
   // ============================================================
   assign precharge = (sel_q == BMS_SEL_BATT)
                      && (slot_cnt_q >= 32'(SLOT_CYC - PRECHARGE_CYC - 1));
   assign div_d = active && !divider_output_disable_q
                  && (precharge || (sel_q == BMS_SEL_AUX0)
                      || ((sel_q == BMS_SEL_AUX1) && !slot_end));

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         div_q <= 1'b0;
      end
      else if (clk_en)
      begin
         div_q <= div_d;
      end
   end

   assign divider_supply_output = div_q;

   // ============================================================
   // Current measurement and accumulation
   // ============================================================
   assign cur_end = active && (cur_cnt_q == 32'(CUR_PERIOD_CYC - 1));
   assign cur_run = active;
   assign cur_dump = cur_end;

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         cur_cnt_q <= 32'h00000000;
      end
      else if (clk_en && active)
      begin
         if (cur_end)
         begin
            cur_cnt_q <= 32'h00000000;
         end
         else
         begin
            cur_cnt_q <= cur_cnt_q + 32'h00000001;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         current_q <= BMS_MEAS_RESET;
      end
      else if (clk_en && cur_end)
      begin
         current_q <= cur_avg;
      end
   end

   // Signed add with clamping at both ends of the count
   assign acc_sum = {2'b00, accumulated_charge_count_q} + {{2{cur_avg[15]}}, cur_avg};

   always_comb
   begin
      if (acc_sum[17])
      begin
         acc_d = BMS_ACCUM_MIN;
      end
      else if (acc_sum[16])
      begin
         acc_d = BMS_ACCUM_MAX;
      end
      else
      begin
         acc_d = acc_sum[15:0];
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         accumulated_charge_count_q <= BMS_MEAS_RESET;
      end
      else if (clk_en)
      begin
         if (wr_accum)
         begin
            accumulated_charge_count_q <= req_hold.wdata;
         end
         else if (cur_end)
         begin
            accumulated_charge_count_q <= acc_d;
         end
      end
   end

   // ============================================================
   // Host register access
   // ============================================================
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         sleep_enable_bit_q <= BMS_SLEEP_EN_RESET;
         divider_output_disable_q <= BMS_DIV_DIS_RESET;
      end
      else if (clk_en && wr_cfg)
      begin
         sleep_enable_bit_q <= req_hold.wdata[BMS_CFG_SLEEP_EN_BIT];
         divider_output_disable_q <= req_hold.wdata[BMS_CFG_DIV_DIS_BIT];
      end
   end

   always_comb
   begin
      rd_mux = 16'h0000;
      case (req_hold.addr)
         BMS_REG_CFG:
         begin
            rd_mux[BMS_CFG_SLEEP_EN_BIT] = sleep_enable_bit_q;
            rd_mux[BMS_CFG_DIV_DIS_BIT] = divider_output_disable_q;
            rd_mux[BMS_CFG_SLEEPING_BIT] = sleeping;
         end
         BMS_REG_CURRENT: rd_mux = current_q;
         BMS_REG_ACCUM: rd_mux = accumulated_charge_count_q;
         BMS_REG_VOLTAGE: rd_mux = voltage_q;
         BMS_REG_AUX0: rd_mux = aux0_q;
         BMS_REG_AUX1: rd_mux = aux1_q;
         default: rd_mux = 16'h0000;
      endcase
   end

   // Answer word stays put until the next request arrives
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         rsp_q <= 16'h0000;
         ack_q <= 1'b0;
      end
      else if (clk_en && access)
      begin
         rsp_q <= rd_mux;
         ack_q <= ~ack_q;
      end
   end

endmodule

/* File: rtl/bms_pkg.sv */
package bms_pkg;

   // ============================================================
   // Clock and timing
   // ============================================================
   localparam int BMS_CLK_MHZ = 100;

   // Bus low timeout window, in microseconds
   localparam int BMS_BUS_LOW_TIMEOUT_MIN_US = 1500000;
   localparam int BMS_BUS_LOW_TIMEOUT_MAX_US = 2200000;
   // Least time of the window, so sleep comes inside it
   localparam int BMS_BUS_LOW_TIMEOUT_CYC = BMS_BUS_LOW_TIMEOUT_MIN_US * BMS_CLK_MHZ;

   // Voltage conversion slot, in microseconds
   localparam int BMS_SLOT_US = 220000;
   localparam int BMS_SLOT_CYC = BMS_SLOT_US * BMS_CLK_MHZ;

   // Current register refresh period, in microseconds
   localparam int BMS_CUR_PERIOD_US = 878000;
   localparam int BMS_CUR_PERIOD_CYC = BMS_CUR_PERIOD_US * BMS_CLK_MHZ;

   // Divider precharge time, least figure, in nanoseconds; rounded up
   localparam int BMS_DIVIDER_PRECHARGE_TIME_NS = 13300000;
   localparam int BMS_DIVIDER_PRECHARGE_CYC =
      (BMS_DIVIDER_PRECHARGE_TIME_NS / 10 * BMS_CLK_MHZ + 99) / 100;

   // ============================================================
   // Register indices on the host access port
   // ============================================================
   localparam logic [2:0] BMS_REG_CFG = 3'h0;
   localparam logic [2:0] BMS_REG_CURRENT = 3'h1;
   localparam logic [2:0] BMS_REG_ACCUM = 3'h2;
   localparam logic [2:0] BMS_REG_VOLTAGE = 3'h3;
   localparam logic [2:0] BMS_REG_AUX0 = 3'h4;
   localparam logic [2:0] BMS_REG_AUX1 = 3'h5;

   // Status/configuration fields
   localparam int BMS_CFG_SLEEP_EN_BIT = 0;
   localparam int BMS_CFG_DIV_DIS_BIT = 1;
   localparam int BMS_CFG_SLEEPING_BIT = 7;

   // Values after reset and accumulator clamp limits
   localparam logic BMS_SLEEP_EN_RESET = 1'b0;
   localparam logic BMS_DIV_DIS_RESET = 1'b0;
   localparam logic [15:0] BMS_MEAS_RESET = 16'h0000;
   localparam logic [15:0] BMS_ACCUM_MAX = 16'hFFFF;
   localparam logic [15:0] BMS_ACCUM_MIN = 16'h0000;

   // ============================================================
   // Types
   // ============================================================
   typedef enum logic [1:0]
   {
      BMS_SEL_BATT = 2'b00,
      BMS_SEL_AUX0 = 2'b01,
      BMS_SEL_AUX1 = 2'b10
   } bms_sel_e;

   typedef enum logic
   {
      BMS_ACTIVE = 1'b0,
      BMS_SLEEP = 1'b1
   } bms_mode_e;

   typedef struct packed
   {
      logic write;
      logic [2:0] addr;
      logic [15:0] wdata;
   } bms_req_s;

   typedef struct packed
   {
      bms_sel_e sel;
      logic ratiometric;
      logic run;
      logic dump;
   } bms_vconv_s;

endpackage

/* File: rtl/bms_link_port.sv */
`timescale 1ns/1ns
module bms_link_port
(
   // Link clock and reset
   input wire logic link_clk,
   input wire logic link_rst_n,
   // Host access
   input wire logic host_req_valid,
   input wire bms_pkg::bms_req_s host_req,
   output logic host_req_ready,
   output logic host_rd_valid,
   output logic [15:0] host_rd_data,
   // Toward the core domain
   output logic req_toggle_q,
   output bms_pkg::bms_req_s req_hold_q,
   input wire logic ack_toggle,
   input wire logic [15:0] rsp_data
);
   import bms_pkg::*;

   logic busy_q;
   logic ack_s1_q;
   logic ack_s2_q;
   logic ack_s3_q;
   logic rd_valid_q;
   logic [15:0] rd_data_q;
   logic ack_seen;

   assign ack_seen = ack_s2_q ^ ack_s3_q;
   assign host_req_ready = ~busy_q;
   assign host_rd_valid = rd_valid_q;
   assign host_rd_data = rd_data_q;

   // ============================================================
   // Acknowledge synchroniser
   // ============================================================
   always_ff @(posedge link_clk)
   begin
      if (!link_rst_n)
      begin
         ack_s1_q <= 1'b0;
         ack_s2_q <= 1'b0;
         ack_s3_q <= 1'b0;
      end
      else
      begin
         ack_s1_q <= ack_toggle;
         ack_s2_q <= ack_s1_q;
         ack_s3_q <= ack_s2_q;
      end
   end

   // ============================================================
   // Request capture; request held stable while busy
   // ============================================================
   always_ff @(posedge link_clk)
   begin
      if (!link_rst_n)
      begin
         busy_q <= 1'b0;
         req_toggle_q <= 1'b0;
         req_hold_q <= '0;
      end
      else if (!busy_q && host_req_valid)
      begin
         busy_q <= 1'b1;
         req_toggle_q <= ~req_toggle_q;
         req_hold_q <= host_req;
      end
      else if (busy_q && ack_seen)
      begin
         busy_q <= 1'b0;
      end
   end

   // ============================================================
   // Read answer; core holds rsp_data until the next request
   // ============================================================
   always_ff @(posedge link_clk)
   begin
      if (!link_rst_n)
      begin
         rd_valid_q <= 1'b0;
         rd_data_q <= 16'h0000;
      end
      else
      begin
         rd_valid_q <= busy_q && ack_seen && !req_hold_q.write;
         if (busy_q && ack_seen && !req_hold_q.write)
         begin
            rd_data_q <= rsp_data;
         end
      end
   end

endmodule

/* File: test/bms_monitor.sv */
`timescale 1ns/1ns
// ====================
// Port checker
module bms_monitor
#(
   parameter int BUS_LOW_CYC = 200,
   parameter int SLOT_CYC = 100,
   parameter int CUR_PERIOD_CYC = 150,
   parameter int PRECHARGE_CYC = 20
)
(
   // Core domain
   input wire logic clock,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire bms_pkg::bms_vconv_s vconv,
   input wire logic cur_run,
   input wire logic cur_dump,
   input wire logic divider_supply_output,
   input wire logic sleeping,
   // Link domain
   input wire logic link_clk,
   input wire logic link_rst_n,
   input wire logic host_req_ready,
   input wire logic host_rd_valid
);
   import bms_pkg::*;
   logic [15:0] slot_q;
   logic [15:0] cur_q;
   logic [15:0] low_q;
   bms_sel_e sel_n;

   // ====================
   // Reference counts
   assign sel_n = (vconv.sel == BMS_SEL_BATT) ? BMS_SEL_AUX0 :
      ((vconv.sel == BMS_SEL_AUX0) ? BMS_SEL_AUX1 : BMS_SEL_BATT);

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         slot_q <= 16'h0000;
      else if (clk_en && vconv.run)
         slot_q <= vconv.dump ? 16'h0000 : slot_q + 16'h0001;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         cur_q <= 16'h0000;
      else if (clk_en && cur_run)
         cur_q <= cur_dump ? 16'h0000 : cur_q + 16'h0001;
   end

   // Edges with both lines low while awake
   always_ff @(posedge clock)
   begin
      if (!rst_n || scl_in || sda_in || sleeping)
         low_q <= 16'h0000;
      else
         low_q <= low_q + 16'h0001;
   end

   // ====================
   // Properties
   sel_step_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && vconv.dump |=> vconv.sel == $past(sel_n)) else $error("select order");
   sel_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      !vconv.dump |=> $stable(vconv.sel)) else $error("select moved mid slot");
   ratio_ref_a: assert property (@(posedge clock) disable iff (!rst_n)
      vconv.ratiometric == (vconv.sel != BMS_SEL_BATT)) else $error("reference choice");
   slot_len_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && vconv.run |-> vconv.dump == (slot_q == SLOT_CYC - 1)) else $error("slot length");
   cur_len_a: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && cur_run |-> cur_dump == (cur_q == CUR_PERIOD_CYC - 1)) else $error("period");
   sleep_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
      sleeping |-> !(vconv.run || cur_run || vconv.dump || cur_dump)) else $error("busy asleep");
   awake_run_a: assert property (@(posedge clock) disable iff (!rst_n)
      !sleeping |-> vconv.run && cur_run) else $error("idle while awake");
   div_sleep_a: assert property (@(posedge clock) disable iff (!rst_n)
      sleeping ##1 sleeping |-> !divider_supply_output) else $error("divider on asleep");
   div_early_a: assert property (@(posedge clock) disable iff (!rst_n)
      vconv.sel == BMS_SEL_BATT && slot_q <= SLOT_CYC - PRECHARGE_CYC - 1
      |-> !divider_supply_output) else $error("divider on too early");
   sleep_in_a: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(sleeping) |-> low_q >= BUS_LOW_CYC && low_q <= BUS_LOW_CYC + 4)
      else $error("sleep entry time");
   wake_up_a: assert property (@(posedge clock) disable iff (!rst_n)
      sleeping && (scl_in || sda_in) |-> ##[1:4] !sleeping) else $error("no wake");
   rd_pulse_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      host_rd_valid |-> host_req_ready ##1 !host_rd_valid) else $error("read answer shape");

   cover property (@(posedge clock) vconv.dump && vconv.sel == BMS_SEL_AUX1);
   cover property (@(posedge clock) $rose(sleeping));
   cover property (@(posedge link_clk) host_rd_valid);
endmodule

/* File: test/bms_host_model.sv */
`timescale 1ns/1ns
// ====================
// Host side of the access port
module bms_host_model
(
   // Link clock and reset
   input wire logic link_clk,
   input wire logic link_rst_n,
   // Request and answer
   output logic host_req_valid,
   output bms_pkg::bms_req_s host_req,
   input wire logic host_req_ready,
   input wire logic host_rd_valid,
   input wire logic [15:0] host_rd_data
);
   import bms_pkg::*;

   initial
   begin
      host_req_valid = 1'b0;
      host_req = bms_req_s'(20'h00000);
   end

   // One whole word; request held until taken
   task automatic xfer(input logic wr, input logic [2:0] a, input logic [15:0] wd,
      output logic [15:0] rd);
      int n;
      n = 0;
      @(posedge link_clk);
      host_req_valid <= 1'b1;
      host_req <= bms_req_s'({wr, a, wd});
      @(posedge link_clk);
      while (host_req_ready !== 1'b1 && n < 64)
      begin
         @(posedge link_clk);
         n++;
      end
      // Released lines carry no stale copy
      host_req_valid <= 1'b0;
      host_req <= bms_req_s'(~host_req);
      n = 0;
      @(posedge link_clk);
      while ((wr ? host_req_ready : host_rd_valid) !== 1'b1 && n < 64)
      begin
         @(posedge link_clk);
         n++;
      end
      rd = (n < 64) ? host_rd_data : 'x;
   endtask
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ns
// ====================
// Bench top
module tb;
   import bms_pkg::*;
   localparam int BL = 200;
   localparam int SL = 100;
   localparam int CP = 150;
   localparam int PC = 20;
   logic clock = 1'b0;
   logic link_clk = 1'b0;
   logic rst_n = 1'b0;
   logic link_rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic scl_in = 1'b1;
   logic sda_in = 1'b1;
   logic [15:0] vconv_avg = 16'h0000;
   logic [15:0] cur_avg = 16'h0000;
   logic host_req_valid, host_req_ready, host_rd_valid, cur_run, cur_dump, sleeping;
   logic divider_supply_output;
   logic [15:0] host_rd_data;
   logic [15:0] rd;
   bms_req_s host_req;
   bms_vconv_s vconv;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int dumps = 0;

   always #5 clock = ~clock;
   always #16 link_clk = ~link_clk;

   bms_sequencer #(.BUS_LOW_CYC(BL), .SLOT_CYC(SL), .CUR_PERIOD_CYC(CP), .PRECHARGE_CYC(PC))
   bms_sequencer_inst
   (
      .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .link_clk(link_clk),
      .link_rst_n(link_rst_n), .host_req_valid(host_req_valid), .host_req(host_req),
      .host_req_ready(host_req_ready), .host_rd_valid(host_rd_valid),
      .host_rd_data(host_rd_data), .scl_in(scl_in), .sda_in(sda_in), .vconv(vconv),
      .vconv_avg(vconv_avg), .cur_run(cur_run), .cur_dump(cur_dump), .cur_avg(cur_avg),
      .divider_supply_output(divider_supply_output), .sleeping(sleeping)
   );

   bms_host_model bms_host_model_inst
   (
      .link_clk(link_clk), .link_rst_n(link_rst_n), .host_req_valid(host_req_valid),
      .host_req(host_req), .host_req_ready(host_req_ready), .host_rd_valid(host_rd_valid),
      .host_rd_data(host_rd_data)
   );

   // ====================
   // Converter stand-in and watchdog
   always @(posedge clock)
   begin
      vconv_avg <= {8'hA5, 6'h00, vconv.sel};
      cyc <= cyc + 1;
      if (cur_dump === 1'b1 && sleeping === 1'b0 && clk_en === 1'b1)
         dumps <= dumps + 1;
      if (cyc == 20000)
      begin
         bad_count++;
         wrap_up();
      end
   end

   // ====================
   // Helpers
   task check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [2:0] a, input logic [15:0] d);
      bms_host_model_inst.xfer(1'b1, a, d, rd);
      check({15'h0000, host_req_ready}, 16'h0001);
   endtask

   task rdc(input logic [2:0] a, input logic [15:0] exp);
      bms_host_model_inst.xfer(1'b0, a, 16'h0000, rd);
      check(rd, exp);
   endtask

   task wait_dump();
      int n;
      n = 0;
      @(posedge clock);
      while (cur_dump !== 1'b1 && n < 400)
      begin
         @(posedge clock);
         n++;
      end
      check({15'h0000, cur_dump}, 16'h0001);
   endtask

   task div_count(input int exp);
      int n;
      n = 0;
      repeat (2) @(posedge clock);
      repeat (3 * SL)
      begin
         @(posedge clock);
         n += (divider_supply_output === 1'b1);
      end
      check(16'(n), 16'(exp));
   endtask

   // ====================
   // Scenarios
   task t_reset();
      rdc(BMS_REG_CURRENT, BMS_MEAS_RESET);
      rdc(BMS_REG_ACCUM, BMS_MEAS_RESET);
      rdc(BMS_REG_CFG, 16'h0000);
      rdc(3'h6, 16'h0000);
   endtask

   task t_volt();
      repeat (3 * SL) @(posedge clock);
      wr(BMS_REG_VOLTAGE, 16'h1234);
      for (int i = 0; i < 3; i++)
         rdc(BMS_REG_VOLTAGE + 3'(i), {8'hA5, 6'h00, 2'(i)});
   endtask

   task t_accum(input logic [15:0] start, input logic [15:0] cur, input logic [15:0] exp);
      @(posedge clock);
      cur_avg <= cur;
      wait_dump();
      wr(BMS_REG_ACCUM, start);
      wait_dump();
      wait_dump();
      rdc(BMS_REG_ACCUM, exp);
      rdc(BMS_REG_CURRENT, cur);
   endtask

   task t_div();
      wr(BMS_REG_CFG, 16'h0002);
      rdc(BMS_REG_CFG, 16'h0002);
      div_count(0);
      wr(BMS_REG_CFG, 16'h0000);
      div_count(PC + 2 * SL);
   endtask

   task t_hold();
      logic [1:0] s;
      @(posedge clock);
      clk_en <= 1'b0;
      @(posedge clock);
      s = vconv.sel;
      repeat (2 * SL) @(posedge clock);
      check({14'h0000, vconv.sel}, {14'h0000, s});
      clk_en <= 1'b1;
   endtask

   task t_sleep();
      logic [15:0] a0;
      int d0;
      int n;
      @(posedge clock);
      scl_in <= 1'b0;
      sda_in <= 1'b0;
      repeat (BL + 50) @(posedge clock);
      check({15'h0000, sleeping}, 16'h0000);
      scl_in <= 1'b1;
      sda_in <= 1'b1;
      wr(BMS_REG_CFG, 16'h0001);
      @(posedge clock);
      cur_avg <= 16'hFFFF;
      wait_dump();
      bms_host_model_inst.xfer(1'b0, BMS_REG_ACCUM, 16'h0000, a0);
      d0 = dumps;
      @(posedge clock);
      scl_in <= 1'b0;
      sda_in <= 1'b0;
      n = 0;
      while (sleeping !== 1'b1 && n < BL + 10)
      begin
         @(posedge clock);
         n++;
      end
      check({15'h0000, sleeping}, 16'h0001);
      repeat (3 * SL) @(posedge clock);
      sda_in <= 1'b1;
      repeat (4) @(posedge clock);
      check({15'h0000, sleeping}, 16'h0000);
      wait_dump();
      bms_host_model_inst.xfer(1'b0, BMS_REG_ACCUM, 16'h0000, rd);
      check(rd, a0 - 16'(dumps - d0));
      rdc(BMS_REG_CFG, 16'h0001);
   endtask

   task wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge link_clk);
      link_rst_n <= 1'b1;
      t_reset();
      t_volt();
      t_accum(16'h0100, 16'hFFF0, 16'h00E0);
      t_accum(16'h0010, 16'hFFE0, 16'h0000);
      t_accum(16'hFFF0, 16'h0100, 16'hFFFF);
      t_div();
      t_hold();
      t_sleep();
      wrap_up();
   end
endmodule

bind bms_sequencer bms_monitor #(.BUS_LOW_CYC(BUS_LOW_CYC), .SLOT_CYC(SLOT_CYC),
   .CUR_PERIOD_CYC(CUR_PERIOD_CYC), .PRECHARGE_CYC(PRECHARGE_CYC)) bms_monitor_inst
(
   .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in),
   .vconv(vconv), .cur_run(cur_run), .cur_dump(cur_dump), .sleeping(sleeping),
   .divider_supply_output(divider_supply_output), .link_clk(link_clk),
   .link_rst_n(link_rst_n), .host_req_ready(host_req_ready), .host_rd_valid(host_rd_valid)
);
